// ===== idp_params.svh
`ifndef IDP_PARAMS_SVH
`define IDP_PARAMS_SVH
// Register indices; byte address is four times the index
`define IDP_IDX_STATUS  4'h0
`define IDP_IDX_CFG_LSB 4'h1
`define IDP_IDX_CFG_MSB 4'h2
`define IDP_IDX_CFG_USB 4'h3
`define IDP_IDX_FREQ0   4'h4
`define IDP_IDX_FREQ3   4'h7
`define IDP_IDX_PHASE0  4'h8
`define IDP_IDX_PHASE1  4'h9
`define IDP_IDX_GAIN_A  4'hA
`define IDP_IDX_GAIN_B  4'hB
`define IDP_IDX_OFFS_A  4'hC
`define IDP_IDX_OFFS_B  4'hD
// Field positions
`define IDP_F_MODE      1:0
`define IDP_F_SEL       3:2
`define IDP_B_FBYP      4
`define IDP_B_ISINC     5
`define IDP_B_NCO       0
`define IDP_B_SSB       1
`define IDP_B_SYNC      2
`define IDP_B_RSPECT    0
// Reset values
`define IDP_RST_CFG     8'h00
`define IDP_RST_FREQ    8'h00
`define IDP_RST_PHASE   8'h00
`define IDP_RST_GAIN    12'hFFF
`define IDP_RST_OFFS    11'h000
// Timing and arithmetic
`define IDP_NCO_MAX_MHZ 320
`define IDP_TRIG_ONE    16'sh4000
`define IDP_TRIG_FRAC   14
`endif

// ===== idp_pkg.sv
package idp_pkg;
  typedef enum logic [1:0] {IDP_DUAL, IDP_SSB, IDP_QMOD, IDP_RSVD} idp_mode_type;
  typedef logic signed [15:0] idp_trig_type;
endpackage

// ===== idp_datapath.sv
// Contract
// - Mode 00 filters A and B separately, no mixing.
// - Each path has four cascaded half-band stages then switchable inverse sinc.
// - Rate select enables 1 to 4 stages for 2x, 4x, 8x or 16x.
// - Full bypass routes samples around every interpolation stage.
// - Mode 01 mixes A = I*cos - Q*sin, B = I*sin + Q*cos.
// - Frequency is 32 bits in four registers, phase 16 bits in two.
// - Oscillator steps every DAC clock; valid only up to 320 MHz.
// - Oscillator off in mixing modes gives quarter-rate 1,0,-1,0 mixing.
// - Sideband select negates B in single-sideband mode.
// - Sine invert bit uses negated sine in the mixer.
// - Gain and offset per channel at indices 0x0A to 0x0D.
// - Offset is added to each channel just before the converter, except A in mode 10.
// - Gain code sets each converter's full-scale current.
// - Frequency is word*fdac/2^32, phase word*pi/2^15 added to accumulator.
// - Half-rate oscillator from zero gives two real +1/-1 up-conversion paths.
// - Strobe high with sync select 0 holds running accumulator at zero.
// - Mode 10 is quadrature modulation mixing I/Q to IF.
// - Quadrature mode holds converter A constant, mixer output to B.
// - Quadrature mode sideband select picks which mixer output feeds B.
// - Quadrature mode keeps gain and offset for converter B active.
`timescale 1ns/1ns
`include "idp_params.svh"
module idp_datapath
  import idp_pkg::*;
#(
  parameter int DW          = 16,
  parameter int AW          = 12,
  parameter int DAC_CLK_MHZ = 100
)
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [AW-1:0]        paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic                      pready_r,
  output logic [31:0]               prdata_r,
  output logic                      pslverr_r,
  input  wire logic signed [DW-1:0] din_i,
  input  wire logic signed [DW-1:0] din_q,
  output logic                      data_req_r,
  input  wire logic                 phase_strobe,
  output logic signed [DW-1:0]      dac_a_r,
  output logic signed [DW-1:0]      dac_b_r,
  output logic [11:0]               gain_a_r,
  output logic [11:0]               gain_b_r
);

  localparam int WW = DW + 17;

  generate
    if (DW < 12 || AW < 6)
      $error("idp_datapath: DW must be at least 12 and AW at least 6");
    if (DAC_CLK_MHZ > `IDP_NCO_MAX_MHZ)
      $error("idp_datapath: oscillator mixing not valid above 320 MHz");
  endgenerate

  function automatic logic signed [DW-1:0] sat(input logic signed [WW-1:0] v);
    logic signed [WW-1:0] hi;
    logic signed [WW-1:0] lo;
    hi = WW'((2 ** (DW - 1)) - 1);
    lo = -hi - WW'(1);
    if (v > hi)
      return hi[DW-1:0];
    else if (v < lo)
      return lo[DW-1:0];
    else
      return v[DW-1:0];
  endfunction

  function automatic logic signed [DW-1:0] neg(input logic signed [DW-1:0] x);
    return sat(-WW'(x));
  endfunction

  function automatic logic signed [DW-1:0] avg(input logic signed [DW-1:0] a,
                                               input logic signed [DW-1:0] b);
    logic signed [DW:0] s;
    s = '0;
    s = {a[DW-1], a} + {b[DW-1], b};
    return s[DW:1];
  endfunction

  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] wd,
                                       input logic [3:0] st);
    return {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic idp_trig_type qtab(input logic [4:0] k);
    unique case (k)
      5'h00: return 16'sh0000;
      5'h01: return 16'sh0646;
      5'h02: return 16'sh0C7C;
      5'h03: return 16'sh1294;
      5'h04: return 16'sh187E;
      5'h05: return 16'sh1E2B;
      5'h06: return 16'sh238E;
      5'h07: return 16'sh289A;
      5'h08: return 16'sh2D41;
      5'h09: return 16'sh3179;
      5'h0A: return 16'sh3537;
      5'h0B: return 16'sh3871;
      5'h0C: return 16'sh3B21;
      5'h0D: return 16'sh3D3F;
      5'h0E: return 16'sh3EC5;
      5'h0F: return 16'sh3FB1;
      default: return `IDP_TRIG_ONE;
    endcase
  endfunction

  function automatic idp_trig_type sine(input logic [5:0] p);
    logic [4:0] q;
    q = {1'b0, p[3:0]};
    unique case (p[5:4])
      2'h0: return qtab(q);
      2'h1: return qtab(5'h10 - q);
      2'h2: return -qtab(q);
      default: return -qtab(5'h10 - q);
    endcase
  endfunction

  // Registers
  logic [7:0]  cfg_lsb_r;
  logic [7:0]  cfg_msb_r;
  logic [7:0]  cfg_usb_r;
  logic [7:0]  freq_r [4];
  logic [7:0]  phase_r [2];
  logic [10:0] offs_a_r;
  logic [10:0] offs_b_r;
  logic [31:0] acc_r;
  logic        phs_lvl_r;

  logic [3:0]  idx;
  logic        acc_ok;
  logic        wr_en;
  logic [31:0] rd_nxt;
  assign idx    = paddr[5:2];
  assign acc_ok = paddr[AW-1:6] == '0 && paddr[1:0] == 2'h0 && idx <= `IDP_IDX_OFFS_B;
  assign wr_en  = psel && penable && pready_r && pwrite && acc_ok;

  // APB handshake, one wait state
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else
    begin
      pready_r  <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && !acc_ok;
      prdata_r  <= (psel && penable && !pready_r && !pwrite && acc_ok) ? rd_nxt : 32'h0;
    end

  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    unique case (idx)
      `IDP_IDX_STATUS:  rd_nxt = {15'h0000, phs_lvl_r, acc_r[31:16]};
      `IDP_IDX_CFG_LSB: rd_nxt = {24'h000000, cfg_lsb_r};
      `IDP_IDX_CFG_MSB: rd_nxt = {24'h000000, cfg_msb_r};
      `IDP_IDX_CFG_USB: rd_nxt = {24'h000000, cfg_usb_r};
      4'h4, 4'h5, 4'h6, 4'h7: rd_nxt = {24'h000000, freq_r[idx[1:0]]};
      `IDP_IDX_PHASE0:  rd_nxt = {24'h000000, phase_r[0]};
      `IDP_IDX_PHASE1:  rd_nxt = {24'h000000, phase_r[1]};
      `IDP_IDX_GAIN_A:  rd_nxt = {20'h00000, gain_a_r};
      `IDP_IDX_GAIN_B:  rd_nxt = {20'h00000, gain_b_r};
      `IDP_IDX_OFFS_A:  rd_nxt = {21'h000000, offs_a_r};
      `IDP_IDX_OFFS_B:  rd_nxt = {21'h000000, offs_b_r};
      default:          rd_nxt = 32'h0000_0000;
    endcase
  end

  // Register writes
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      cfg_lsb_r  <= `IDP_RST_CFG;
      cfg_msb_r  <= `IDP_RST_CFG;
      cfg_usb_r  <= `IDP_RST_CFG;
      freq_r     <= '{default: `IDP_RST_FREQ};
      phase_r    <= '{default: `IDP_RST_PHASE};
      gain_a_r   <= `IDP_RST_GAIN;
      gain_b_r   <= `IDP_RST_GAIN;
      offs_a_r   <= `IDP_RST_OFFS;
      offs_b_r   <= `IDP_RST_OFFS;
    end
    else if (wr_en && pstrb[0])
    begin
      unique case (idx)
        `IDP_IDX_CFG_LSB: cfg_lsb_r <= pwdata[7:0];
        `IDP_IDX_CFG_MSB: cfg_msb_r <= pwdata[7:0];
        `IDP_IDX_CFG_USB: cfg_usb_r <= pwdata[7:0];
        4'h4, 4'h5, 4'h6, 4'h7: freq_r[idx[1:0]] <= pwdata[7:0];
        `IDP_IDX_PHASE0:  phase_r[0] <= pwdata[7:0];
        `IDP_IDX_PHASE1:  phase_r[1] <= pwdata[7:0];
        `IDP_IDX_GAIN_A:  gain_a_r <= 12'(wr16({4'h0, gain_a_r}, pwdata, pstrb));
        `IDP_IDX_GAIN_B:  gain_b_r <= 12'(wr16({4'h0, gain_b_r}, pwdata, pstrb));
        `IDP_IDX_OFFS_A:  offs_a_r <= 11'(wr16({5'h00, offs_a_r}, pwdata, pstrb));
        `IDP_IDX_OFFS_B:  offs_b_r <= 11'(wr16({5'h00, offs_b_r}, pwdata, pstrb));
        default: ;
      endcase
    end
    else if (wr_en && pstrb[1])
    begin
      unique case (idx)
        `IDP_IDX_GAIN_A:  gain_a_r <= 12'(wr16({4'h0, gain_a_r}, pwdata, pstrb));
        `IDP_IDX_GAIN_B:  gain_b_r <= 12'(wr16({4'h0, gain_b_r}, pwdata, pstrb));
        `IDP_IDX_OFFS_A:  offs_a_r <= 11'(wr16({5'h00, offs_a_r}, pwdata, pstrb));
        `IDP_IDX_OFFS_B:  offs_b_r <= 11'(wr16({5'h00, offs_b_r}, pwdata, pstrb));
        default: ;
      endcase
    end

  idp_mode_type mode;
  logic [1:0]   rsel;
  logic         fbyp;
  logic         nco_on;
  logic         ssb;
  logic [31:0]  freq_w;
  logic [15:0]  phase_w;
  assign mode    = idp_mode_type'(cfg_lsb_r[`IDP_F_MODE]);
  assign rsel    = cfg_lsb_r[`IDP_F_SEL];
  assign fbyp    = cfg_lsb_r[`IDP_B_FBYP];
  assign nco_on  = cfg_msb_r[`IDP_B_NCO];
  assign ssb     = cfg_msb_r[`IDP_B_SSB];
  assign freq_w  = {freq_r[3], freq_r[2], freq_r[1], freq_r[0]};
  assign phase_w = {phase_r[1], phase_r[0]};

  // Phase strobe pin synchroniser, change taken when stages two and three agree
  logic [2:0] phs_q_r;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      phs_q_r   <= 3'h0;
      phs_lvl_r <= 1'b0;
    end
    else
    begin
      phs_q_r   <= {phs_q_r[1:0], phase_strobe};
      phs_lvl_r <= (phs_q_r[1] == phs_q_r[2]) ? phs_q_r[2] : phs_lvl_r;
    end

  // Oscillator accumulator
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      acc_r <= 32'h0000_0000;
    else if (nco_on && !cfg_msb_r[`IDP_B_SYNC] && phs_lvl_r)
      acc_r <= 32'h0000_0000;
    else if (nco_on)
      acc_r <= acc_r + freq_w;

  // Quarter-rate sequence counter
  logic [1:0] qtr_r;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      qtr_r <= 2'h0;
    else
      qtr_r <= qtr_r + 2'h1;

  // Sine and cosine terms
  logic [15:0]  ph;
  idp_trig_type cos_r;
  idp_trig_type sin_r;
  idp_trig_type sin_t;
  idp_trig_type cos_t;
  assign ph = acc_r[31:16] + phase_w;
  always_comb
  begin
    if (nco_on)
    begin
      sin_t = sine(ph[15:10]);
      cos_t = sine(ph[15:10] + 6'h10);
    end
    else
    begin
      sin_t = qtr_r[0] ? (qtr_r[1] ? -`IDP_TRIG_ONE : `IDP_TRIG_ONE) : 16'sh0000;
      cos_t = qtr_r[0] ? 16'sh0000 : (qtr_r[1] ? -`IDP_TRIG_ONE : `IDP_TRIG_ONE);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      cos_r <= 16'sh0000;
      sin_r <= 16'sh0000;
    end
    else
    begin
      cos_r <= cos_t;
      sin_r <= cfg_usb_r[`IDP_B_RSPECT] ? -sin_t : sin_t;
    end

  // Sample request and capture
  logic [3:0]          cnt_r;
  logic [3:0]          top_msk;
  logic [3:0]          cnt_nxt;
  logic signed [DW-1:0] in_r [2];
  assign top_msk = 4'((5'h02 << rsel) - 5'h01);
  assign cnt_nxt = cnt_r + 4'h1;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      cnt_r      <= 4'h0;
      data_req_r <= 1'b0;
      in_r       <= '{default: '0};
    end
    else
    begin
      cnt_r      <= cnt_nxt;
      data_req_r <= fbyp || ((cnt_nxt & top_msk) == 4'h0);
      if (data_req_r)
        in_r <= '{din_i, din_q};
    end

  // Half-band interpolation cascade, stage 0 runs at the full rate
  logic signed [DW-1:0] hb_i  [2][4];
  logic signed [DW-1:0] hb_o  [2][4];
  logic signed [DW-1:0] prv_r [2][4];
  logic signed [DW-1:0] cur_r [2][4];
  logic signed [DW-1:0] out_r [2][4];

  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    for (genvar j = 0; j < 4; j++)
    begin : g_hb
      localparam logic [3:0] MSK = 4'((5'h02 << j) - 5'h01);
      logic en;
      assign en = !fbyp && (j <= int'(rsel));
      if (j == 3)
      begin : g_top
        assign hb_i[c][j] = in_r[c];
      end
      else
      begin : g_mid
        assign hb_i[c][j] = hb_o[c][j+1];
      end
      assign hb_o[c][j] = en ? out_r[c][j] : hb_i[c][j];
      always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
          prv_r[c][j] <= '0;
          cur_r[c][j] <= '0;
          out_r[c][j] <= '0;
        end
        else
        begin
          if ((cnt_r & MSK) == 4'h0)
          begin
            prv_r[c][j] <= cur_r[c][j];
            cur_r[c][j] <= hb_i[c][j];
          end
          if ((cnt_r & (MSK >> 1)) == 4'h0)
            out_r[c][j] <= cnt_r[j] ? avg(prv_r[c][j], cur_r[c][j]) : cur_r[c][j];
        end
    end
  end

  // Complex mixer
  logic signed [DW-1:0] mi;
  logic signed [DW-1:0] mq;
  logic signed [DW-1:0] mx_a;
  logic signed [DW-1:0] mx_b;
  logic signed [DW-1:0] mix_a_r;
  logic signed [DW-1:0] mix_b_r;
  logic signed [WW-1:0] pa;
  logic signed [WW-1:0] pb;
  assign mi = hb_o[0][0];
  assign mq = hb_o[1][0];
  assign pa = WW'(mi) * WW'(cos_r) - WW'(mq) * WW'(sin_r);
  assign pb = WW'(mi) * WW'(sin_r) + WW'(mq) * WW'(cos_r);
  assign mx_a = sat(pa >>> `IDP_TRIG_FRAC);
  assign mx_b = sat(pb >>> `IDP_TRIG_FRAC);

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      mix_a_r <= '0;
      mix_b_r <= '0;
    end
    else
    begin
      unique case (mode)
        IDP_SSB:
        begin
          mix_a_r <= mx_a;
          mix_b_r <= ssb ? neg(mx_b) : mx_b;
        end
        IDP_QMOD:
        begin
          mix_a_r <= '0;
          mix_b_r <= ssb ? mx_a : mx_b;
        end
        default:
        begin
          mix_a_r <= mi;
          mix_b_r <= mq;
        end
      endcase
    end

  // Inverse sinc, (-x0 + 18 x1 - x2) / 16
  logic signed [DW-1:0] s1_r [2];
  logic signed [DW-1:0] s2_r [2];
  logic signed [DW-1:0] mx  [2];
  logic signed [DW-1:0] is_y [2];
  assign mx = '{mix_a_r, mix_b_r};
  for (genvar c = 0; c < 2; c++)
  begin : g_isinc
    logic signed [WW-1:0] acc;
    assign acc = (WW'(s1_r[c]) <<< 4) + (WW'(s1_r[c]) <<< 1) - WW'(mx[c]) - WW'(s2_r[c]);
    assign is_y[c] = cfg_lsb_r[`IDP_B_ISINC] ? sat(acc >>> 4) : s1_r[c];
  end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      s1_r <= '{default: '0};
      s2_r <= '{default: '0};
    end
    else
    begin
      s1_r <= mx;
      s2_r <= s1_r;
    end

  // Offset addition at the converter input
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      dac_a_r <= '0;
      dac_b_r <= '0;
    end
    else
    begin
      if (mode == IDP_QMOD)
        dac_a_r <= '0;
      else
        dac_a_r <= sat(WW'(is_y[0]) + WW'($signed(offs_a_r)));
      dac_b_r <= sat(WW'(is_y[1]) + WW'($signed(offs_b_r)));
    end

  // Gain codes drive the full-scale current of each converter directly

endmodule

// ===== idp_checker.sv
`timescale 1ns/1ns
`include "idp_params.svh"
module idp_checker
  import idp_pkg::*;
#(
  parameter int DW = 16,
  parameter int AW = 12
)
(
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [AW-1:0]        paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [3:0]           pstrb,
  input wire logic                 pready_r,
  input wire logic [31:0]          prdata_r,
  input wire logic                 pslverr_r,
  input wire logic                 data_req_r,
  input wire logic signed [DW-1:0] dac_a_r,
  input wire logic [11:0]          gain_a_r,
  input wire logic [11:0]          gain_b_r
);
  logic       wr_w;
  logic [3:0] idx_w;
  logic [7:0] cfg_r;
  logic [5:0] age_r;
  logic [5:0] gap_r;
  logic [4:0] quad_r;
  assign wr_w  = psel && penable && pwrite && pready_r && !pslverr_r && (pstrb != 4'h0);
  assign idx_w = paddr[5:2];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Mirror of the low configuration byte
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      cfg_r <= 8'h00;
    else if (wr_w && idx_w == `IDP_IDX_CFG_LSB && pstrb[0])
      cfg_r <= pwdata[7:0];
  // Cycles since the last write to the low configuration byte
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      age_r <= 6'h00;
    else if (wr_w && idx_w == `IDP_IDX_CFG_LSB)
      age_r <= 6'h00;
    else if (age_r != 6'h3F)
      age_r <= age_r + 6'h01;
  // Spacing between sample requests
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      gap_r <= 6'h00;
    else if (data_req_r)
      gap_r <= 6'h01;
    else if (gap_r != 6'h3F)
      gap_r <= gap_r + 6'h01;
  // Cycles spent in quadrature mode
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      quad_r <= 5'h00;
    else if (cfg_r[1:0] != IDP_QMOD)
      quad_r <= 5'h00;
    else if (quad_r != 5'h1F)
      quad_r <= quad_r + 5'h01;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  property p_apb_answer;
    s_setup ##1 s_access |=> pready_r ##1 !pready_r;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing wrong");
  property p_err_read;
    pready_r && pslverr_r |-> prdata_r == 32'h0000_0000;
  endproperty
  a_err_read: assert property (p_err_read) else $error("error read not zero");
  property p_gain_a_wr;
    wr_w && idx_w == `IDP_IDX_GAIN_A && pstrb == 4'hF |=> gain_a_r == 12'($past(pwdata));
  endproperty
  a_gain_a_wr: assert property (p_gain_a_wr) else $error("gain a not written");
  property p_gain_b_wr;
    wr_w && idx_w == `IDP_IDX_GAIN_B && pstrb == 4'hF |=> gain_b_r == 12'($past(pwdata));
  endproperty
  a_gain_b_wr: assert property (p_gain_b_wr) else $error("gain b not written");
  property p_gain_a_hold;
    !(wr_w && idx_w == `IDP_IDX_GAIN_A) |=> $stable(gain_a_r);
  endproperty
  a_gain_a_hold: assert property (p_gain_a_hold) else $error("gain a changed");
  property p_gain_b_hold;
    !(wr_w && idx_w == `IDP_IDX_GAIN_B) |=> $stable(gain_b_r);
  endproperty
  a_gain_b_hold: assert property (p_gain_b_hold) else $error("gain b changed");
  property p_quad_a;
    quad_r == 5'h1F |-> dac_a_r == '0;
  endproperty
  a_quad_a: assert property (p_quad_a) else $error("dac a not held");
  property p_req_gap;
    data_req_r && age_r == 6'h3F |-> gap_r == (cfg_r[4] ? 6'h01 : 6'h02 << cfg_r[3:2]);
  endproperty
  a_req_gap: assert property (p_req_gap) else $error("request spacing wrong");
endmodule
bind idp_datapath idp_checker #(.DW(DW), .AW(AW)) u_idp_checker (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .pready_r(pready_r), .prdata_r(prdata_r), .pslverr_r(pslverr_r),
  .data_req_r(data_req_r), .dac_a_r(dac_a_r), .gain_a_r(gain_a_r), .gain_b_r(gain_b_r));

// ===== idp_sample_src.sv
`timescale 1ns/1ns
module idp_sample_src
#(
  parameter int DW = 16
)
(
  input  wire logic                 data_req_r,
  input  wire logic signed [DW-1:0] i_val,
  input  wire logic signed [DW-1:0] q_val,
  output logic signed [DW-1:0]      din_i,
  output logic signed [DW-1:0]      din_q
);
  // Sample valid only while requested, inverted otherwise; levels kept small
  assign din_i = data_req_r ? i_val : ~i_val;
  assign din_q = data_req_r ? q_val : ~q_val;
endmodule

// ===== tb_interp_dac_nco_mixer_datapath.sv
`timescale 1ns/1ns
`include "idp_params.svh"
module tb_interp_dac_nco_mixer_datapath;
  localparam logic signed [15:0] AMP = 16'sh03E8;
  logic               clk;
  logic               rst_n;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [11:0]        paddr;
  logic [31:0]        pwdata;
  logic [3:0]         pstrb;
  logic               pready_r;
  logic [31:0]        prdata_r;
  logic               pslverr_r;
  logic signed [15:0] din_i;
  logic signed [15:0] din_q;
  logic signed [15:0] i_val;
  logic signed [15:0] q_val;
  logic               data_req_r;
  logic               phase_strobe;
  logic signed [15:0] dac_a_r;
  logic signed [15:0] dac_b_r;
  logic [11:0]        gain_a_r;
  logic [11:0]        gain_b_r;
  int                 num_errors;
  int                 comparisons;
  int                 cyc;
  idp_datapath #(.DW(16), .AW(12), .DAC_CLK_MHZ(100)) u_idp_datapath (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready_r(pready_r), .prdata_r(prdata_r), .pslverr_r(pslverr_r),
    .din_i(din_i), .din_q(din_q), .data_req_r(data_req_r), .phase_strobe(phase_strobe),
    .dac_a_r(dac_a_r), .dac_b_r(dac_b_r), .gain_a_r(gain_a_r), .gain_b_r(gain_b_r));
  idp_sample_src #(.DW(16)) u_idp_sample_src (.data_req_r(data_req_r), .i_val(i_val),
    .q_val(q_val), .din_i(din_i), .din_q(din_q));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [11:0] ra(input logic [3:0] i);
    return {6'h00, i, 2'b00};
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready_r !== 1'b1)
      @(posedge clk);
    rd = prdata_r;
    er = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic cfg(input logic [7:0] l, input logic [7:0] m, input logic [7:0] u);
    wr(ra(`IDP_IDX_CFG_LSB), {24'h0, l});
    wr(ra(`IDP_IDX_CFG_MSB), {24'h0, m});
    wr(ra(`IDP_IDX_CFG_USB), {24'h0, u});
    repeat (60) @(posedge clk);
  endtask
  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    apb(1'b0, ra(`IDP_IDX_GAIN_A), 32'h0, r, e);
    chk("gain_a reset", r, 32'h0000_0FFF);
    wr(ra(`IDP_IDX_GAIN_A), 32'h0000_0800);
    wr(ra(`IDP_IDX_GAIN_B), 32'h0000_0123);
    chk("gain_a", 32'(gain_a_r), 32'h0000_0800);
    chk("gain_b", 32'(gain_b_r), 32'h0000_0123);
    apb(1'b1, 12'h038, 32'h0000_0055, r, e);
    chk("unmapped", 32'(e), 32'h1);
    $display("test regs done");
  endtask
  task automatic t_rate;
    logic [31:0] n;
    for (int s = 0; s < 5; s++)
    begin
      cfg((s == 4) ? 8'h10 : 8'(s << 2), 8'h00, 8'h00);
      n = 32'h0;
      repeat (64)
      begin
        @(posedge clk);
        n = n + 32'(data_req_r);
      end
      chk("req count", n, (s == 4) ? 32'h40 : 32'(64 >> (s + 1)));
    end
    $display("test rate done");
  endtask
  task automatic t_mix(input logic [1:0] k);
    logic [31:0] pa;
    i_val <= AMP;
    q_val <= 16'sh0000;
    cfg(8'h11, {6'h0, k[0], 1'b0}, {7'h0, k[1]});
    pa = 32'(dac_a_r);
    repeat (4)
    begin
      @(posedge clk);
      chk("dac_b band", 32'(dac_b_r), (k[0] ^ k[1]) ? -pa : pa);
      chk("mix zero", 32'(dac_a_r == 0 && dac_b_r == 0), 32'h0);
      pa = 32'(dac_a_r);
    end
    $display("test mix done");
  endtask
  task automatic t_nco;
    logic [31:0] r;
    logic [31:0] pa;
    logic        e;
    for (int i = 4; i < 10; i++)
      wr(ra(4'(i)), (i == 7) ? 32'h0000_0080 : 32'h0);
    i_val <= AMP;
    q_val <= -(AMP >>> 1);
    cfg(8'h11, 8'h01, 8'h00);
    phase_strobe <= 1'b1;
    repeat (12) @(posedge clk);
    apb(1'b0, ra(`IDP_IDX_STATUS), 32'h0, r, e);
    chk("status", r & 32'h0001_FFFF, 32'h0001_0000);
    chk("dac_a held", 32'(dac_a_r), 32'(AMP));
    phase_strobe <= 1'b0;
    repeat (60) @(posedge clk);
    repeat (4)
    begin
      pa = 32'(dac_a_r);
      @(posedge clk);
      chk("dac_a sign", 32'(dac_a_r), -pa);
      chk("dac_b sign", 32'(dac_b_r) * 2, -32'(dac_a_r));
    end
    $display("test nco done");
  endtask
  task automatic t_dual;
    wr(ra(`IDP_IDX_OFFS_A), 32'h0000_0005);
    wr(ra(`IDP_IDX_OFFS_B), 32'h0000_07FD);
    i_val <= AMP;
    q_val <= -16'sh012C;
    cfg(8'h10, 8'h00, 8'h00);
    chk("dac_a dual", 32'(dac_a_r), 32'(AMP) + 32'h5);
    chk("dac_b dual", 32'(dac_b_r), -32'h0000_012F);
    cfg(8'h2F, 8'h00, 8'h00);
    repeat (60) @(posedge clk);
    chk("dac_a filt", 32'(dac_a_r), 32'(AMP) + 32'h5);
    chk("dac_b filt", 32'(dac_b_r), -32'h0000_012F);
    $display("test dual done");
  endtask
  task automatic t_quad;
    logic [31:0] b0;
    logic [31:0] b1;
    wr(ra(`IDP_IDX_OFFS_B), 32'h0000_0007);
    q_val <= 16'sh0000;
    cfg(8'h12, 8'h02, 8'h00);
    b0 = 32'(dac_b_r);
    @(posedge clk);
    b1 = 32'(dac_b_r);
    @(posedge clk);
    chk("dac_b pair", 32'(dac_b_r) + b0, 32'h0000_000E);
    chk("dac_a quad", 32'(dac_a_r), 32'h0);
    chk("dac_b moves", 32'(b0 == b1), 32'h0);
    $display("test quad done");
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      wrap_up;
    end
  end
  initial
  begin
    {rst_n, psel, penable, pwrite, phase_strobe} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    i_val = 16'sh0000;
    q_val = 16'sh0000;
    num_errors = 0;
    comparisons = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_rate;
    for (int k = 0; k < 4; k++)
      t_mix(2'(k));
    t_nco;
    t_dual;
    t_quad;
    wrap_up;
  end
endmodule
